// ### logic/cwd_config_word_decoder.sv
// The implementer's own choice: the plain strobed port.
`include "cwd_defines.svh"
module cwd_config_word_decoder (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Programming port
	input wire logic prog_mode,
	input wire logic [`CWD_AW-1:0] addr,
	input wire logic [`CWD_DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [`CWD_DW-1:0] rdata,
	// Core fetch path
	input wire logic core_fetch,
	input wire logic [`CWD_AW-1:0] core_addr,
	output logic core_fetch_ok,
	// Memory array handshake
	output logic mem_wr,
	output logic mem_rd,
	output logic [`CWD_AW-1:0] mem_addr,
	output logic [`CWD_DW-1:0] mem_wdata,
	input wire logic [`CWD_DW-1:0] mem_rdata,
	// Decoded options
	output logic calib_space_protect,
	output logic prog_space_protect,
	output logic powerup_delay_timer,
	output logic watchdog_counter,
	output logic crystal_resonator_mode,
	output cwd_pkg::cwd_osc_type clock_source_select,
	// Oscillator pins
	input wire logic osc_pin_one,
	input wire logic osc_two_latch,
	output logic osc_pin_one_data,
	output logic osc_pin_two_val,
	output logic osc_pin_two_oe
);
	logic [`CWD_DW-1:0] cfg_r;
	logic [`CWD_DW-1:0] cfg_nxt;
	logic rd_pend_r;
	logic [2:0] pin_sync_r;
	logic in_test, in_cal, in_prog, cfg_hit, prog_ok, cal_wr_ok, wr_ok, rd_ok;

	assign in_test = addr >= `CWD_TEST_BASE;
	assign cfg_hit = addr == `CWD_CFG_ADDR;
	assign in_cal = addr >= `CWD_CAL_BASE && addr <= `CWD_CAL_LAST;
	assign in_prog = addr <= `CWD_USER_LAST;
	assign prog_ok = cfg_r[`CWD_B_PHI] && cfg_r[`CWD_B_PLO];
	assign cal_wr_ok = cfg_r[`CWD_B_CAL];
	assign wr_ok = prog_mode && ((in_prog && prog_ok) || (in_cal && cal_wr_ok) || cfg_hit);
	assign rd_ok = prog_mode && ((in_prog && prog_ok) || (in_test && !cfg_hit));

	// Programmed bits clear; ones never return without erase
	assign cfg_nxt = cfg_r & wdata;

	// Shadow of the stored word, erased until programmed
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= `CWD_ERASED;
		end else if (wr && prog_mode && cfg_hit) begin
			cfg_r <= cfg_nxt;
		end
	end

	// Array access gating
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			mem_addr <= `CWD_RD_NONE;
			mem_wdata <= `CWD_RD_NONE;
			rd_pend_r <= 1'b0;
		end else begin
			mem_wr <= wr && wr_ok && !cfg_hit;
			mem_rd <= rd && rd_ok;
			mem_addr <= addr;
			mem_wdata <= wdata;
			rd_pend_r <= rd && prog_mode && cfg_hit;
		end
	end

	// Read data: config word direct, zero for every other address
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= `CWD_RD_NONE;
		end else if (rd && prog_mode && cfg_hit) begin
			rdata <= cfg_r;
		end else if (rd && rd_ok) begin
			rdata <= `CWD_RD_NONE;
		end else begin
			rdata <= `CWD_RD_NONE;
		end
	end

	// Core may never fetch from test space
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			core_fetch_ok <= 1'b0;
		end else begin
			core_fetch_ok <= core_fetch && core_addr < `CWD_TEST_BASE;
		end
	end

	// Decoded options; reserved bits never read
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			calib_space_protect <= 1'b0;
			prog_space_protect <= 1'b0;
			powerup_delay_timer <= 1'b0;
			watchdog_counter <= 1'b1;
			crystal_resonator_mode <= 1'b0;
			clock_source_select <= cwd_pkg::CWD_OSC_INT;
		end else begin
			calib_space_protect <= !cfg_r[`CWD_B_CAL];
			prog_space_protect <= !prog_ok;
			powerup_delay_timer <= !cfg_r[`CWD_B_PDLY];
			watchdog_counter <= cfg_r[`CWD_B_WDOG];
			crystal_resonator_mode <= !cfg_r[`CWD_B_OSC];
			clock_source_select <= cfg_r[`CWD_B_OSC] ? cwd_pkg::CWD_OSC_INT
				: cwd_pkg::CWD_OSC_XTAL;
		end
	end

	// Pin one sampled through three stages
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_sync_r <= `CWD_SYNC_IDLE;
			osc_pin_one_data <= 1'b1;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], osc_pin_one};
			// Crystal owns the pin; forced low even while it toggles
			if (!cfg_r[`CWD_B_OSC]) begin
				osc_pin_one_data <= 1'b0;
			end else if (pin_sync_r[2] == pin_sync_r[1]) begin
				osc_pin_one_data <= pin_sync_r[2];
			end
		end
	end

	// Pin two driven only in internal oscillator mode
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_pin_two_val <= 1'b0;
			osc_pin_two_oe <= 1'b0;
		end else begin
			osc_pin_two_val <= osc_two_latch;
			osc_pin_two_oe <= cfg_r[`CWD_B_OSC];
		end
	end

	logic unused_ok;
	assign unused_ok = rd_pend_r ^ (^mem_rdata);

	property p_wdog;
		@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> watchdog_counter == $past(cfg_r[`CWD_B_WDOG]);
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog decode wrong");
	property p_pdly;
		@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> powerup_delay_timer != $past(cfg_r[`CWD_B_PDLY]);
	endproperty
	a_pdly: assert property (p_pdly) else $error("powerup decode wrong");
	property p_osc;
		@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> crystal_resonator_mode == (clock_source_select == cwd_pkg::CWD_OSC_XTAL);
	endproperty
	a_osc: assert property (p_osc) else $error("clock select mismatch");
	property p_cal;
		@(posedge clk_sys) disable iff (!rst_b)
		wr && in_cal && !cfg_r[`CWD_B_CAL] |=> !mem_wr;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration write leaked");
	property p_prog;
		@(posedge clk_sys) disable iff (!rst_b)
		(wr || rd) && in_prog && !prog_ok |=> !mem_wr && !mem_rd;
	endproperty
	a_prog: assert property (p_prog) else $error("program access leaked");
	property p_test;
		@(posedge clk_sys) disable iff (!rst_b)
		(wr || rd) && !prog_mode |=> !mem_wr && !mem_rd && rdata == `CWD_RD_NONE;
	endproperty
	a_test: assert property (p_test) else $error("access outside programming");
	property p_fetch;
		@(posedge clk_sys) disable iff (!rst_b)
		core_fetch && core_addr >= `CWD_TEST_BASE |=> !core_fetch_ok;
	endproperty
	a_fetch: assert property (p_fetch) else $error("core fetched test space");
	property p_cfgrd;
		@(posedge clk_sys) disable iff (!rst_b)
		rd && prog_mode && cfg_hit |=> rdata == $past(cfg_r);
	endproperty
	a_cfgrd: assert property (p_cfgrd) else $error("config read wrong");
	property p_mono;
		@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> (cfg_r & ~$past(cfg_r)) == `CWD_RD_NONE;
	endproperty
	a_mono: assert property (p_mono) else $error("bit returned to one");
	property p_pin2;
		@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> osc_pin_two_oe == $past(cfg_r[`CWD_B_OSC]);
	endproperty
	a_pin2: assert property (p_pin2) else $error("pin two enable wrong");
	property p_pin2v;
		@(posedge clk_sys) disable iff (!rst_b)
		1'b1 |=> osc_pin_two_val == $past(osc_two_latch);
	endproperty
	a_pin2v: assert property (p_pin2v) else $error("pin two level wrong");
	property p_pin1;
		@(posedge clk_sys) disable iff (!rst_b)
		!cfg_r[`CWD_B_OSC] |=> !osc_pin_one_data;
	endproperty
	a_pin1: assert property (p_pin1) else $error("pin one read in crystal mode");
	property p_rdz;
		@(posedge clk_sys) disable iff (!rst_b)
		rd && !(prog_mode && cfg_hit) |=> rdata == `CWD_RD_NONE;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data leaked");
	property p_cfgwr;
		@(posedge clk_sys) disable iff (!rst_b)
		wr && prog_mode && cfg_hit |=> cfg_r == ($past(cfg_r) & $past(wdata));
	endproperty
	a_cfgwr: assert property (p_cfgwr) else $error("config write wrong");
	c_cfgwr: cover property (@(posedge clk_sys) disable iff (!rst_b) wr && prog_mode && cfg_hit);
	c_xtal: cover property (@(posedge clk_sys) disable iff (!rst_b) crystal_resonator_mode);
	c_block: cover property (@(posedge clk_sys) disable iff (!rst_b) rd && in_prog && !prog_ok);
	c_wdoff: cover property (@(posedge clk_sys) disable iff (!rst_b) !watchdog_counter);
	c_pin1: cover property (@(posedge clk_sys) disable iff (!rst_b) osc_pin_one_data);
endmodule

// ### logic/cwd_defines.svh
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH
`define CWD_AW 14
`define CWD_DW 14
`define CWD_CFG_ADDR 14'h2007
`define CWD_TEST_BASE 14'h2000
`define CWD_CAL_BASE 14'h2008
`define CWD_CAL_LAST 14'h20FF
`define CWD_USER_LAST 14'h0FFF
`define CWD_ERASED 14'h3FFF
`define CWD_RD_NONE 14'h0000
`define CWD_B_CAL 7
`define CWD_B_PHI 5
`define CWD_B_PLO 4
`define CWD_B_PDLY 3
`define CWD_B_WDOG 2
`define CWD_B_OSC 0
`define CWD_SYNC_IDLE 3'h7
`endif

// ### logic/cwd_pkg.sv
package cwd_pkg;
	typedef enum logic [1:0] {
		CWD_OSC_XTAL = 2'h1,
		CWD_OSC_INT = 2'h2
	} cwd_osc_type;
endpackage

// ### tb/cwd_prog_array.sv
module cwd_prog_array (
	// Clock
	input wire logic clk_sys,
	// Array side of the decoder
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [13:0] mem_addr,
	input wire logic [13:0] mem_wdata,
	output logic [13:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] cell_r [16384];
	logic [13:0] last_r = 14'h3FFF;
	// Erased cells read all ones
	initial begin
		foreach (cell_r[i]) cell_r[i] = 14'h3FFF;
	end
	// Idle bus shows inverse of last value
	always @(posedge clk_sys) begin
		if (mem_wr) cell_r[mem_addr] = mem_wdata;
		if (mem_rd) last_r = cell_r[mem_addr];
		else last_r = ~last_r;
		mem_rdata <= last_r;
	end
endmodule

// ### tb/config_word_decoder_bench.sv
module config_word_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_b, prog_mode, wr, rd, core_fetch, core_fetch_ok;
	logic osc_pin_one, osc_two_latch, osc_pin_one_data, osc_pin_two_val, osc_pin_two_oe;
	logic [13:0] addr, wdata, rdata, core_addr, mem_addr, mem_wdata, mem_rdata, got_d, w;
	logic [13:0] got_a, got_w;
	logic mem_wr, mem_rd, got_wr, got_rd, cal_p, prg_p, pdly, wdog, xtal;
	cwd_pkg::cwd_osc_type clock_source_select;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [13:0] words [3] = '{14'h3EBD, 14'h3EB9, 14'h3EB1};
	wire [13:0] opt = {6'h00, cal_p, prg_p, pdly, wdog, xtal, clock_source_select, osc_pin_two_oe};
	cwd_config_word_decoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .prog_mode(prog_mode),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_fetch(core_fetch),
		.core_addr(core_addr), .core_fetch_ok(core_fetch_ok), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.calib_space_protect(cal_p), .prog_space_protect(prg_p), .powerup_delay_timer(pdly),
		.watchdog_counter(wdog), .crystal_resonator_mode(xtal),
		.clock_source_select(clock_source_select), .osc_pin_one(osc_pin_one),
		.osc_two_latch(osc_two_latch), .osc_pin_one_data(osc_pin_one_data),
		.osc_pin_two_val(osc_pin_two_val), .osc_pin_two_oe(osc_pin_two_oe));
	cwd_prog_array array_model (.clk_sys(clk_sys), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	// Expected decoded options for a stored word
	function automatic logic [13:0] eo(input logic [13:0] v);
		cwd_pkg::cwd_osc_type s;
		s = v[0] ? cwd_pkg::CWD_OSC_INT : cwd_pkg::CWD_OSC_XTAL;
		return {6'h00, ~v[7], ~(v[5] & v[4]), ~v[3], v[2], ~v[0], s, v[0]};
	endfunction
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t flag got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One strobe cycle; samples the answer in the cycle after it
	task automatic acc(input logic w_en, input logic [13:0] a, input logic [13:0] d);
		@(posedge clk_sys);
		wr <= w_en;
		rd <= !w_en;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		got_wr = mem_wr;
		got_rd = mem_rd;
		got_a = mem_addr;
		got_w = mem_wdata;
		got_d = rdata;
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{rst_b, prog_mode, wr, rd, core_fetch, osc_pin_one, osc_two_latch} <= 7'h00;
		{addr, wdata, core_addr} <= '0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle();
		chk(opt, eo(14'h3FFF));
		core_fetch <= 1'b1;
		core_addr <= 14'h0FFF;
		@(posedge clk_sys);
		core_addr <= 14'h2007;
		#1 chk_bit(core_fetch_ok, 1'b1);
		@(posedge clk_sys);
		core_fetch <= 1'b0;
		#1 chk_bit(core_fetch_ok, 1'b0);
		acc(1'b1, 14'h2007, 14'h0000);
		chk_bit(got_wr, 1'b0);
		acc(1'b0, 14'h2007, 14'h0000);
		chk(got_d, 14'h0000);
		acc(1'b0, 14'h2010, 14'h0000);
		chk_bit(got_rd, 1'b0);
		settle();
		chk(opt, eo(14'h3FFF));
		$display("test refusal done");
		prog_mode <= 1'b1;
		acc(1'b0, 14'h2007, 14'h0000);
		chk(got_d, 14'h3FFF);
		foreach (words[i]) begin
			acc(1'b1, 14'h2007, words[i]);
			settle();
			chk(opt, eo(words[i]));
			acc(1'b0, 14'h2007, 14'h0000);
			chk(got_d, words[i]);
		end
		$display("test options done");
		acc(1'b1, 14'h0010, 14'h1234);
		chk_bit(got_wr, 1'b1);
		chk(got_a, 14'h0010);
		chk(got_w, 14'h1234);
		acc(1'b0, 14'h0010, 14'h0000);
		chk_bit(got_rd, 1'b1);
		acc(1'b1, 14'h2010, 14'h0321);
		chk_bit(got_wr, 1'b1);
		acc(1'b0, 14'h2010, 14'h0000);
		chk_bit(got_rd, 1'b1);
		w = 14'h3E21;
		acc(1'b1, 14'h2007, w);
		settle();
		chk(opt, eo(w));
		acc(1'b1, 14'h0010, 14'h1234);
		chk_bit(got_wr, 1'b0);
		acc(1'b0, 14'h0010, 14'h0000);
		chk(got_d, 14'h0000);
		chk_bit(got_rd, 1'b0);
		acc(1'b1, 14'h2010, 14'h0321);
		chk_bit(got_wr, 1'b0);
		$display("test protection done");
		osc_two_latch <= 1'b1;
		osc_pin_one <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1 chk_bit(osc_pin_two_val, 1'b1);
		chk_bit(osc_pin_one_data, 1'b1);
		acc(1'b1, 14'h2007, 14'h3E20);
		repeat (6) @(posedge clk_sys);
		#1 chk(opt, eo(14'h3E20));
		chk_bit(osc_pin_one_data, 1'b0);
		$display("test oscillator done");
		conclude();
	end
endmodule
